// File: design/dims_pkg.sv
package dims_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ROW_W = 13;
  localparam int BANK_W = 2;
  localparam int COL_W = 3;
  // Power-up and DLL timing
  localparam int POWERUP_WAIT_US = 200;
  localparam int CKE_WAIT_NS = 400;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKE_WAIT_CYC = (CKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CYC = 200;
  localparam int MIN_REFRESH_CNT = 2;
  localparam int MODE_SET_CYC = 2;
  localparam int XSNR_CYC = 4;
  localparam int XSRD_CYC = 200;
  localparam int SHORT_BURST = 4;
  localparam int LONG_BURST = 8;
  // Bank codes for mode set targets
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT1 = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;
  localparam logic [1:0] BANK_EXT3 = 2'h3;
  // Mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int EMR1_DLL_BIT = 0;
  localparam int EMR1_CAL_LSB = 7;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] WR_FAST_CODE = 3'h1;
  localparam logic [2:0] WR_DEFAULT = 3'h2;
  localparam logic [2:0] CL_DEFAULT = 3'h3;
  localparam int FAST_CLK_PS = 1875;
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESELECT = 4'hf;
  typedef enum logic [3:0] {
    DIMS_ERR_NONE, DIMS_ERR_MODE_BUSY, DIMS_ERR_BURST_CUT, DIMS_ERR_SR_BUSY,
    DIMS_ERR_PD_BUSY, DIMS_ERR_XSNR, DIMS_ERR_XSRD, DIMS_ERR_ILLEGAL, DIMS_ERR_WAP
  } dims_err_e;
endpackage

// File: design/dims_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dims_link_if;
  import dims_pkg::*;
  logic cke;
  logic [3:0] cmd;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0] addr;
  logic termination_enable;
  logic write_mask;
  modport ctrl (output cke, cmd, bank, addr, termination_enable, write_mask);
  modport mem (input cke, cmd, bank, addr, termination_enable, write_mask);
endinterface
`default_nettype wire

// File: design/dims_burst_order.sv
`timescale 1ns/1ps
`default_nettype none
module dims_burst_order (
  input wire logic [dims_pkg::COL_W-1:0] start_col, // Starting column bits
  input wire logic [dims_pkg::COL_W-1:0] beat, // Beat index
  input wire logic long_burst, // High for length 8
  input wire logic interleave, // Burst type
  output logic [dims_pkg::COL_W-1:0] col // Column for this beat
);
  import dims_pkg::*;
  logic [1:0] low;
  always_comb begin
    if (interleave) begin
      low = start_col[1:0] ^ beat[1:0];
    end else begin
      low = start_col[1:0] + beat[1:0];
    end
    col[1:0] = low;
    if (long_burst) begin
      col[2] = start_col[2] ^ beat[2];
    end else begin
      col[2] = start_col[2];
    end
  end
endmodule
`default_nettype wire

// File: design/dims_mem_end.sv
`timescale 1ns/1ps
`default_nettype none
module dims_mem_end #(
  parameter int CLK_PERIOD_PS = 2500 // Controller clock period
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Async reset, active low
  dims_link_if.mem link, // Command side
  output logic [dims_pkg::ROW_W-1:0] mode_reg, // Mode register
  output logic [dims_pkg::ROW_W-1:0] ext1_reg, // Extended register 1
  output logic [dims_pkg::ROW_W-1:0] ext2_reg, // Extended register 2
  output logic [dims_pkg::ROW_W-1:0] ext3_reg, // Extended register 3
  output logic [3:0] mode_written, // Registers written once
  output logic termination_on, // Termination active
  output logic self_refresh, // In self refresh
  output logic power_down, // In power-down
  output logic calibrating, // Calibration mode
  output logic dll_ready, // DLL locked
  output logic [dims_pkg::COL_W-1:0] burst_col, // Current burst column
  output logic burst_active, // Burst in progress
  output logic beat_masked, // Current write beat masked
  output dims_pkg::dims_err_e err_code // Last violation
);
  import dims_pkg::*;
  logic [3:0] cmd;
  logic cke_prev;
  logic [3:0] open_banks;
  logic [3:0] busy_cnt;
  logic [3:0] burst_left;
  logic [COL_W-1:0] burst_start;
  logic [COL_W-1:0] beat_idx;
  logic burst_write;
  logic [7:0] dll_cnt;
  logic [7:0] xs_cnt;
  logic [COL_W-1:0] order_col;
  logic all_idle;
  logic is_col_cmd;
  logic is_active_cmd;
  logic long_bl;

  assign cmd = link.cmd;
  assign all_idle = (open_banks == 4'h0) && (busy_cnt == 4'h0) && !burst_active;
  assign is_col_cmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  assign is_active_cmd = (cmd != CMD_NOP) && (cmd != CMD_DESELECT);
  assign long_bl = (mode_reg[MR_BL_LSB +: 3] == BL_CODE_8);

  function automatic logic [3:0] bank_bit(input logic [BANK_W-1:0] b);
    bank_bit = 4'h1 << b;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= link.cke;
    end
  end

  // Mode set capture; termination level ignored in decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= '0;
      ext1_reg <= '0;
      ext2_reg <= '0;
      ext3_reg <= '0;
      mode_written <= 4'h0;
    end else if (cke_prev && link.cke && cmd == CMD_MODE_SET && all_idle) begin
      mode_written <= mode_written | bank_bit(link.bank);
      case (link.bank)
        BANK_MODE: mode_reg <= link.addr;
        BANK_EXT1: ext1_reg <= link.addr;
        BANK_EXT2: ext2_reg <= link.addr;
        default: ext3_reg <= link.addr;
      endcase
    end
  end

  // Bank and busy tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_banks <= 4'h0;
      busy_cnt <= 4'h0;
    end else if (cke_prev && link.cke) begin
      busy_cnt <= (busy_cnt != 4'h0) ? busy_cnt - 4'h1 : 4'h0;
      case (cmd)
        CMD_ACTIVATE: open_banks <= open_banks | bank_bit(link.bank);
        CMD_PRECHARGE: begin
          open_banks <= link.addr[AP_BIT] ? 4'h0 : open_banks & ~bank_bit(link.bank);
          busy_cnt <= 4'(MODE_SET_CYC);
        end
        CMD_MODE_SET: busy_cnt <= 4'(MODE_SET_CYC);
        default: ;
      endcase
    end
  end

  // Burst engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_active <= 1'b0;
      burst_left <= 4'h0;
      burst_start <= '0;
      beat_idx <= '0;
      burst_write <= 1'b0;
      burst_col <= '0;
      beat_masked <= 1'b0;
    end else begin
      beat_masked <= burst_active && burst_write && link.write_mask;
      burst_col <= order_col;
      if (burst_active) begin
        beat_idx <= beat_idx + 3'h1;
        burst_left <= burst_left - 4'h1;
        if (burst_left == 4'h1) begin
          burst_active <= 1'b0;
        end
      end else if (cke_prev && link.cke && is_col_cmd) begin
        burst_active <= 1'b1;
        burst_left <= long_bl ? 4'(LONG_BURST) : 4'(SHORT_BURST);
        burst_start <= link.addr[COL_W-1:0];
        beat_idx <= '0;
        burst_write <= (cmd == CMD_WRITE);
      end
    end
  end

  dims_burst_order u_order (
    .start_col(burst_start),
    .beat(beat_idx),
    .long_burst(long_bl),
    .interleave(mode_reg[MR_BT_BIT]),
    .col(order_col)
  );

  // Low-power states from clock enable transitions
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      self_refresh <= 1'b0;
      power_down <= 1'b0;
      termination_on <= 1'b0;
      xs_cnt <= 8'h0;
    end else begin
      termination_on <= link.termination_enable && !self_refresh && link.cke;
      if (xs_cnt != 8'h0) begin
        xs_cnt <= xs_cnt - 8'h1;
      end
      if (cke_prev && !link.cke) begin
        if (cmd == CMD_REFRESH && all_idle) begin
          self_refresh <= 1'b1;
        end else if (!self_refresh) begin
          power_down <= 1'b1;
        end
      end else if (!cke_prev && link.cke) begin
        if (self_refresh) begin
          xs_cnt <= 8'(XSRD_CYC);
        end
        self_refresh <= 1'b0;
        power_down <= 1'b0;
      end
    end
  end

  // DLL lock counter and calibration mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_cnt <= 8'h0;
      dll_ready <= 1'b0;
      calibrating <= 1'b0;
    end else begin
      if (cke_prev && link.cke && cmd == CMD_MODE_SET && all_idle &&
          ((link.bank == BANK_MODE && link.addr[MR_DLLRST_BIT]) ||
           (link.bank == BANK_EXT1 && !link.addr[EMR1_DLL_BIT]))) begin
        dll_cnt <= 8'(DLL_LOCK_CYC);
        dll_ready <= 1'b0;
      end else if (dll_cnt != 8'h0) begin
        dll_cnt <= dll_cnt - 8'h1;
        dll_ready <= (dll_cnt == 8'h1);
      end
      if (cke_prev && link.cke && cmd == CMD_MODE_SET && link.bank == BANK_EXT1 && all_idle) begin
        calibrating <= (link.addr[EMR1_CAL_LSB +: 3] != CAL_EXIT);
      end
    end
  end

  // Violation reporting, latest wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_code <= DIMS_ERR_NONE;
    end else if (cke_prev && link.cke && is_active_cmd && burst_active && !is_col_cmd) begin
      err_code <= DIMS_ERR_BURST_CUT;
    end else if (cke_prev && link.cke && cmd == CMD_MODE_SET && !all_idle) begin
      err_code <= DIMS_ERR_MODE_BUSY;
    end else if (cke_prev && !link.cke && !all_idle) begin
      err_code <= (cmd == CMD_REFRESH) ? DIMS_ERR_SR_BUSY : DIMS_ERR_PD_BUSY;
    end else if (calibrating && !link.cke) begin
      err_code <= DIMS_ERR_ILLEGAL;
    end else if (xs_cnt > 8'(XSRD_CYC - XSNR_CYC) && link.cke && is_active_cmd) begin
      err_code <= DIMS_ERR_XSNR;
    end else if (xs_cnt != 8'h0 && cmd == CMD_READ) begin
      err_code <= DIMS_ERR_XSRD;
    end else if (CLK_PERIOD_PS < FAST_CLK_PS && is_col_cmd && cmd == CMD_WRITE &&
                 link.addr[AP_BIT]) begin
      err_code <= DIMS_ERR_WAP;
    end
  end
endmodule
`default_nettype wire

// File: design/dims_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module dims_ctrl_end #(
  parameter int POWERUP_CYC = dims_pkg::POWERUP_WAIT_CYC, // Power-up wait
  parameter int CLK_PERIOD_PS = 2500, // Memory clock period
  parameter int WR_TIME_PS = 15000 // Write recovery time
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Async reset, active low
  dims_link_if.ctrl link, // Command side
  input wire logic odt_req, // Termination request
  output logic init_done // Ready for normal use
);
  import dims_pkg::*;
  typedef enum logic [3:0] {
    DIMS_S_PWR, DIMS_S_CKE, DIMS_S_PREA1, DIMS_S_EMR2, DIMS_S_EMR3, DIMS_S_EMR1,
    DIMS_S_MRDLL, DIMS_S_PREA2, DIMS_S_REF, DIMS_S_MR, DIMS_S_CALDEF, DIMS_S_CALEXIT,
    DIMS_S_DONE
  } dims_state_e;
  localparam int WR_CYC = (WR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] WR_CODE = (CLK_PERIOD_PS < FAST_CLK_PS) ? WR_FAST_CODE :
                                   3'(WR_CYC - 1);
  dims_state_e state;
  logic [17:0] wait_cnt;
  logic [7:0] dll_cnt;
  logic [1:0] ref_cnt;
  logic [ROW_W-1:0] op_mode;

  assign op_mode = {1'b0, WR_CODE, 1'b0, 1'b0, CL_DEFAULT, 1'b0, BL_CODE_4};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DIMS_S_PWR;
      wait_cnt <= 18'(POWERUP_CYC);
      dll_cnt <= 8'h0;
      ref_cnt <= 2'h0;
      init_done <= 1'b0;
      link.cke <= 1'b0;
      link.cmd <= CMD_NOP;
      link.bank <= '0;
      link.addr <= '0;
      link.termination_enable <= 1'b0;
      link.write_mask <= 1'b0;
    end else begin
      link.cmd <= CMD_NOP;
      link.termination_enable <= init_done && odt_req;
      if (dll_cnt != 8'h0) begin
        dll_cnt <= dll_cnt - 8'h1;
      end
      if (wait_cnt != 18'h0) begin
        wait_cnt <= wait_cnt - 18'h1;
      end else begin
        wait_cnt <= 18'(MODE_SET_CYC);
        case (state)
          DIMS_S_PWR: begin
            link.cke <= 1'b1;
            wait_cnt <= 18'(CKE_WAIT_CYC);
            state <= DIMS_S_CKE;
          end
          DIMS_S_CKE: state <= DIMS_S_PREA1;
          DIMS_S_PREA1: begin
            link.cmd <= CMD_PRECHARGE;
            link.addr <= 13'h0400;
            state <= DIMS_S_EMR2;
          end
          DIMS_S_EMR2: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_EXT2;
            link.addr <= '0;
            state <= DIMS_S_EMR3;
          end
          DIMS_S_EMR3: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_EXT3;
            state <= DIMS_S_EMR1;
          end
          DIMS_S_EMR1: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_EXT1;
            link.addr <= '0;
            state <= DIMS_S_MRDLL;
          end
          DIMS_S_MRDLL: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_MODE;
            link.addr <= op_mode | (13'h1 << MR_DLLRST_BIT);
            dll_cnt <= 8'(DLL_LOCK_CYC);
            state <= DIMS_S_PREA2;
          end
          DIMS_S_PREA2: begin
            link.cmd <= CMD_PRECHARGE;
            link.addr <= 13'h0400;
            ref_cnt <= 2'(MIN_REFRESH_CNT);
            state <= DIMS_S_REF;
          end
          DIMS_S_REF: begin
            link.cmd <= CMD_REFRESH;
            wait_cnt <= 18'h8;
            ref_cnt <= ref_cnt - 2'h1;
            if (ref_cnt == 2'h1) begin
              state <= DIMS_S_MR;
            end
          end
          DIMS_S_MR: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_MODE;
            link.addr <= op_mode;
            state <= DIMS_S_CALDEF;
          end
          DIMS_S_CALDEF: begin
            if (dll_cnt == 8'h0) begin
              link.cmd <= CMD_MODE_SET;
              link.bank <= BANK_EXT1;
              link.addr <= 13'(CAL_DEFAULT) << EMR1_CAL_LSB;
              state <= DIMS_S_CALEXIT;
            end else begin
              wait_cnt <= 18'h0;
            end
          end
          DIMS_S_CALEXIT: begin
            link.cmd <= CMD_MODE_SET;
            link.bank <= BANK_EXT1;
            link.addr <= 13'(CAL_EXIT) << EMR1_CAL_LSB;
            state <= DIMS_S_DONE;
          end
          DIMS_S_DONE: begin
            init_done <= 1'b1;
            wait_cnt <= 18'h0;
          end
          default: state <= DIMS_S_PWR;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/dims_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dims_link_sva #(
  parameter int POWERUP_CYC = 20 // Power-up wait
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic cke, // Clock enable
  input wire logic [3:0] cmd, // Command
  input wire logic [dims_pkg::BANK_W-1:0] bank, // Bank select
  input wire logic [dims_pkg::ROW_W-1:0] addr, // Address
  input wire logic [dims_pkg::ROW_W-1:0] mode_reg, // Mode register
  input wire logic [dims_pkg::ROW_W-1:0] ext1_reg, // Extended register 1
  input wire logic [3:0] mode_written, // Written flags
  input wire logic termination_on, // Termination active
  input wire logic self_refresh, // In self refresh
  input wire logic init_done // Init finished
);
  import dims_pkg::*;
  int pu_cnt;
  logic [7:0] dll_cnt;
  logic mset;
  assign mset = cke && (cmd == CMD_MODE_SET);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt <= 0;
    end else if (pu_cnt < POWERUP_CYC) begin
      pu_cnt <= pu_cnt + 1;
    end
  end
  // Clocks since the last DLL reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_cnt <= 8'h00;
    end else if (mset && bank == BANK_MODE && addr[MR_DLLRST_BIT]) begin
      dll_cnt <= 8'h00;
    end else if (dll_cnt != 8'hff) begin
      dll_cnt <= dll_cnt + 8'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ext2_set; mset && bank == BANK_EXT2; endsequence
  sequence ext3_set; mset && bank == BANK_EXT3; endsequence
  sequence ext1_dll_on; mset && bank == BANK_EXT1 && !addr[EMR1_DLL_BIT]; endsequence
  sequence dll_rst; mset && bank == BANK_MODE && addr[MR_DLLRST_BIT]; endsequence
  sequence pre_all; cke && cmd == CMD_PRECHARGE && addr[AP_BIT]; endsequence
  powerup_wait_a: assert property (cke |-> pu_cnt >= POWERUP_CYC - 1)
    else $error("clock enable raised too early");
  cke_settle_a: assert property ($rose(cke) |-> (cmd == CMD_NOP || cmd == CMD_DESELECT) [*8])
    else $error("command too soon after clock enable");
  mode_capture_a: assert property (mset && bank == BANK_MODE |=> mode_reg == $past(addr))
    else $error("mode register not captured");
  ext1_capture_a: assert property (mset && bank == BANK_EXT1 |=> ext1_reg == $past(addr))
    else $error("extended register 1 not captured");
  mode_spacing_a: assert property (mset |=> !mset [*2])
    else $error("mode sets too close");
  sr_term_off_a: assert property (self_refresh |-> !termination_on)
    else $error("termination on in self refresh");
  ext_order_a: assert property (ext2_set |-> ##[1:8] ext3_set ##[1:8] ext1_dll_on)
    else $error("extended register order broken");
  dll_reset_pre_a: assert property (dll_rst |-> ##[1:8] pre_all)
    else $error("no precharge after DLL reset");
  cal_delay_a: assert property (mset && bank == BANK_EXT1 &&
    addr[EMR1_CAL_LSB +: 3] == CAL_DEFAULT |-> dll_cnt >= 8'd200)
    else $error("calibration too soon after DLL reset");
  init_final_a: assert property ($rose(init_done) |-> ##[0:4] (mode_written == 4'hf &&
    ext1_reg[EMR1_CAL_LSB +: 3] == CAL_EXIT && !mode_reg[MR_DLLRST_BIT]))
    else $error("init finished in wrong state");
endmodule
`default_nettype wire

// File: testbench/tb_ddr2_init_and_mode_set.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_init_and_mode_set;
  import dims_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic init_done, dll_a, ton_a, sr_a, ton_b, sr_b, pd_b, burst_b;
  logic [ROW_W-1:0] mr_a, e1_a, mr_b, e1_b, e2_b, e3_b;
  logic [3:0] mw_a, mw_b;
  dims_err_e err_b;
  logic [COL_W-1:0] bc_b;
  logic bm_b, cal_b;
  logic odt_req = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  dims_link_if link_a ();
  dims_link_if link_b ();
  always #20 core_clk = ~core_clk;
  dims_ctrl_end #(.POWERUP_CYC(20), .CLK_PERIOD_PS(1500)) i_dims_ctrl_end (.core_clk(core_clk),
    .rst_n(rst_n), .link(link_a), .odt_req(odt_req), .init_done(init_done));
  dims_mem_end #(.CLK_PERIOD_PS(1500)) i_dims_mem_end (.core_clk(core_clk), .rst_n(rst_n),
    .link(link_a), .mode_reg(mr_a), .ext1_reg(e1_a), .ext2_reg(), .ext3_reg(),
    .mode_written(mw_a), .termination_on(ton_a), .self_refresh(sr_a), .power_down(),
    .calibrating(), .dll_ready(dll_a), .burst_col(), .burst_active(), .beat_masked(),
    .err_code());
  dims_mem_end #(.CLK_PERIOD_PS(1500)) i_dims_mem_end_2 (.core_clk(core_clk), .rst_n(rst_n),
    .link(link_b), .mode_reg(mr_b), .ext1_reg(e1_b), .ext2_reg(e2_b), .ext3_reg(e3_b),
    .mode_written(mw_b), .termination_on(ton_b), .self_refresh(sr_b), .power_down(pd_b),
    .calibrating(cal_b), .dll_ready(), .burst_col(bc_b), .burst_active(burst_b),
    .beat_masked(bm_b), .err_code(err_b));
  dims_link_sva #(.POWERUP_CYC(20)) i_dims_link_sva (.core_clk(core_clk), .rst_n(rst_n),
    .cke(link_a.cke), .cmd(link_a.cmd), .bank(link_a.bank), .addr(link_a.addr),
    .mode_reg(mr_a), .ext1_reg(e1_a), .mode_written(mw_a), .termination_on(ton_a),
    .self_refresh(sr_a), .init_done(init_done));
  task automatic chk_val(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_err(input dims_err_e got, input dims_err_e exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [ROW_W-1:0] a);
    @(negedge core_clk);
    link_b.cmd = c;
    link_b.bank = b;
    link_b.addr = a;
    @(negedge core_clk);
    link_b.cmd = CMD_NOP;
    link_b.addr = ~a;
  endtask
  task automatic test_burst_order;
    int m, s, k, n;
    logic [COL_W-1:0] e;
    for (m = 0; m < 4; m++) begin
      n = m[1] ? 8 : 4;
      // Burst type on bit 3, length code 2 or 3
      issue(CMD_MODE_SET, 2'h0, {9'h023, m[0], 2'h1, m[1]});
      for (s = 0; s < n; s++) begin
        issue(CMD_READ, 2'h0, 13'(s));
        for (k = 0; k < n; k++) begin
          @(negedge core_clk);
          e = m[0] ? (s[2:0] ^ k[2:0]) : {s[2] ^ k[2], s[1:0] + k[1:0]};
          chk_val({10'h000, bc_b}, {10'h000, e});
        end
      end
    end
    issue(CMD_MODE_SET, 2'h0, 13'h0232);
  endtask
  task automatic test_mode_regs;
    logic [ROW_W-1:0] v [4];
    int b;
    v = '{13'h0232, 13'h0380, 13'h0080, 13'h0000};
    @(negedge core_clk);
    link_b.cke = 1'b1;
    idle(3);
    for (b = 0; b < 4; b++) begin
      issue(CMD_MODE_SET, b[1:0], v[b]);
      idle(2);
    end
    chk_val(mr_b, v[0]);
    chk_val(e1_b, v[1]);
    chk_val(e2_b, v[2]);
    chk_val(e3_b, v[3]);
    chk_val({9'h000, mw_b}, 13'h000f);
    chk_val({12'h000, cal_b}, 13'h0001);
    link_b.cke = 1'b0;
    idle(2);
    chk_err(err_b, DIMS_ERR_ILLEGAL);
    link_b.cke = 1'b1;
    idle(2);
    issue(CMD_MODE_SET, 2'h1, 13'h0000);
    idle(2);
    chk_val({12'h000, cal_b}, 13'h0000);
  endtask
  task automatic test_refusals;
    issue(CMD_ACTIVATE, 2'h0, 13'h0010);
    idle(2);
    issue(CMD_WRITE, 2'h0, 13'h0400);
    chk_err(err_b, DIMS_ERR_WAP);
    idle(8);
    link_b.write_mask = 1'b1;
    issue(CMD_WRITE, 2'h0, 13'h0000);
    chk_val({12'h000, burst_b}, 13'h0001);
    issue(CMD_MODE_SET, 2'h0, 13'h0233);
    idle(1);
    chk_val(mr_b, 13'h0232);
    chk_err(err_b, DIMS_ERR_BURST_CUT);
    chk_val({12'h000, bm_b}, 13'h0001);
    link_b.write_mask = 1'b0;
    idle(8);
    issue(CMD_MODE_SET, 2'h0, 13'h0233);
    idle(1);
    chk_val(mr_b, 13'h0232);
    chk_err(err_b, DIMS_ERR_MODE_BUSY);
    link_b.cke = 1'b0;
    idle(2);
    chk_err(err_b, DIMS_ERR_PD_BUSY);
    link_b.cke = 1'b1;
    idle(2);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400);
    idle(4);
  endtask
  task automatic test_low_power;
    link_b.cke = 1'b0;
    idle(3);
    chk_val({12'h000, pd_b}, 13'h0001);
    link_b.cke = 1'b1;
    idle(3);
    chk_val({12'h000, pd_b}, 13'h0000);
    link_b.termination_enable = 1'b1;
    link_b.cmd = CMD_REFRESH;
    link_b.cke = 1'b0;
    idle(1);
    link_b.cmd = CMD_NOP;
    idle(2);
    chk_val({12'h000, sr_b}, 13'h0001);
    chk_val({12'h000, ton_b}, 13'h0000);
    link_b.cke = 1'b1;
    idle(1);
    chk_val({12'h000, ton_b}, 13'h0000);
    issue(CMD_ACTIVATE, 2'h0, 13'h0000);
    chk_err(err_b, DIMS_ERR_XSNR);
    idle(4);
    issue(CMD_READ, 2'h0, 13'h0000);
    chk_err(err_b, DIMS_ERR_XSRD);
  endtask
  task automatic test_init;
    int i;
    for (i = 0; i < 3000 && init_done !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    // Last DLL enable restarts the lock count
    idle(205);
    chk_val({12'h000, init_done}, 13'h0001);
    chk_val({9'h000, mw_a}, 13'h000f);
    chk_val({10'h000, mr_a[MR_WR_LSB +: 3]}, {10'h000, WR_FAST_CODE});
    chk_val({10'h000, e1_a[EMR1_CAL_LSB +: 3]}, {10'h000, CAL_EXIT});
    chk_val({12'h000, mr_a[MR_DLLRST_BIT]}, 13'h0000);
    chk_val({12'h000, e1_a[EMR1_DLL_BIT]}, 13'h0000);
    chk_val({12'h000, dll_a}, 13'h0001);
    odt_req = 1'b1;
    idle(2);
    chk_val({12'h000, ton_a}, 13'h0001);
    odt_req = 1'b0;
    idle(2);
    chk_val({12'h000, ton_a}, 13'h0000);
  endtask
  initial begin
    link_b.cke = 1'b0;
    link_b.cmd = CMD_NOP;
    link_b.bank = 2'h0;
    link_b.addr = 13'h0000;
    link_b.termination_enable = 1'b0;
    link_b.write_mask = 1'b0;
    idle(6);
    rst_n = 1'b1;
    test_mode_regs();
    test_burst_order();
    test_refusals();
    test_low_power();
    test_init();
    finish_test();
  end
endmodule
`default_nettype wire
